// ===== sync_burst_sram_control.v
// Control logic of a pipelined synchronous burst memory.
`timescale 1ns/1ps
`include "burst_sram_defines.vh"
// Functional notes
// - Eight active-low lane write enables; low marks that lane for writing.
// - Global write low writes all lanes, ignoring gate and lane enables.
// - First and third selects active low, second active high.
// - Burst counter advances on an edge where step input is low.
// - Processor or cache strobe, active low, loads an external address.
// - Two low address bits preset the burst counter on a load.
// - Order select low gives linear modulo-four increment of low bits.
// - Counter returns to the loaded value on the fifth clock.
// - Sleep request high puts memory in standby; low operates normally.
// - Sleep request defaults low (pulled down), leaving memory active.
// - Deselect strap low gives dual-cycle, high gives single-cycle deselect.
// - Global write and gate both high means read, all lanes active.
// - Gate low writes lanes with low enables; none low means read.
// - Data drivers stay off throughout any write.
// - Active-low output enable; outputs drive only while it is low.
// - Parity strap low activates ninth-bit lanes; high disables them.
// - Single-cycle deselect turns outputs off at once; dual waits a cycle.
// - Select low: processor strobe reads; cache strobe reads or writes.
// - No strobe: step low continues burst, step high suspends.
// - Output enable high kills drivers at once; low only enables reads.
module sync_burst_sram_control #(
  parameter AW = `ADDR_BITS,
  parameter LANES = `LANES,
  parameter LW = `LANE_BITS + 1
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire [AW-1:0] addr_i,
  input wire select_low_first_n_i,
  input wire select_high_second_i,
  input wire select_low_third_n_i,
  input wire processor_strobe_n_i,
  input wire cache_strobe_n_i,
  input wire burst_step_n_i,
  input wire global_write_n_i,
  input wire byte_write_gate_n_i,
  input wire [LANES-1:0] lane_write_n_i,
  input wire output_enable_n_i,
  input wire sleep_request_i,
  input wire burst_order_sel_i,
  input wire deselect_latency_sel_i,
  input wire parity_lane_strap_n_i,
  input wire [LANES*LW-1:0] data_lanes_i,
  output wire [LANES*LW-1:0] data_lanes_o,
  output wire [LANES*LW-1:0] data_lanes_oe_o,
  output wire rd_valid_o,
  input wire rd_ready_i,
  output wire [LANES*LW-1:0] rd_data_o,
  output wire sleeping_o,
  output wire [1:0] burst_addr_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_WRITE = 3'b100;
  localparam DW = LANES * LW;

  // Synchronisers for pins from outside the clock domain.
  reg [AW-1:0] addr_s1_reg, addr_s2_reg;
  reg [13:0] ctl_s1_reg, ctl_s2_reg;
  reg [LANES-1:0] lane_s1_reg, lane_s2_reg;
  reg [DW-1:0] din_s1_reg, din_s2_reg;
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      addr_s1_reg <= {AW{1'b0}};
      addr_s2_reg <= {AW{1'b0}};
      // Idle levels: all three selects high (chip deselected), strobes and steps high, writes off,
      // sleep low, deselect strap and parity strap high.
      ctl_s1_reg <= 14'h3_0FE;
      ctl_s2_reg <= 14'h3_0FE;
      lane_s1_reg <= {LANES{1'b1}};
      lane_s2_reg <= {LANES{1'b1}};
      din_s1_reg <= {DW{1'b0}};
      din_s2_reg <= {DW{1'b0}};
    end else begin
      addr_s1_reg <= addr_i;
      addr_s2_reg <= addr_s1_reg;
      ctl_s1_reg <= {parity_lane_strap_n_i, deselect_latency_sel_i, burst_order_sel_i,
                     sleep_request_i, output_enable_n_i, byte_write_gate_n_i,
                     global_write_n_i, burst_step_n_i, cache_strobe_n_i,
                     processor_strobe_n_i, select_low_third_n_i, select_high_second_i,
                     select_low_first_n_i, 1'b0};
      ctl_s2_reg <= ctl_s1_reg;
      lane_s1_reg <= lane_write_n_i;
      lane_s2_reg <= lane_s1_reg;
      din_s1_reg <= data_lanes_i;
      din_s2_reg <= din_s1_reg;
    end
  end
  wire e1_n = ctl_s2_reg[1];
  wire e2 = ctl_s2_reg[2];
  wire e3_n = ctl_s2_reg[3];
  wire psp_n = ctl_s2_reg[4];
  wire psc_n = ctl_s2_reg[5];
  wire step_n = ctl_s2_reg[6];
  wire gw_n = ctl_s2_reg[7];
  wire bw_n = ctl_s2_reg[8];
  wire oe_n = ctl_s2_reg[9];
  wire sleep = ctl_s2_reg[10];
  wire order_il = ctl_s2_reg[11];
  wire single_desel = ctl_s2_reg[12];
  wire parity_off = ctl_s2_reg[13];

  wire selected = !e1_n && e2 && !e3_n;
  wire proc_start = selected && !psp_n;
  wire cache_start = selected && psp_n && !psc_n;
  wire deselect = !psc_n && !selected;
  wire load = proc_start || cache_start;
  wire cont = psp_n && psc_n;

  // Lane write decode.
  reg [LANES-1:0] lane_we;
  always @* begin
    if (!gw_n) begin
      lane_we = {LANES{1'b1}};
    end else if (bw_n) begin
      lane_we = {LANES{1'b0}};
    end else begin
      lane_we = ~lane_s2_reg;
    end
  end
  wire write_req = |lane_we;

  // Burst counter.
  reg [1:0] load_low_reg;
  reg [1:0] count_reg;
  reg [AW-1:0] base_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  wire [1:0] linear_addr = load_low_reg + count_reg;
  wire [1:0] inter_addr = load_low_reg ^ count_reg;
  wire [1:0] low_addr = order_il ? inter_addr : linear_addr;
  wire active = (state_reg != ST_IDLE);
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      load_low_reg <= `CNT_ZERO;
      count_reg <= `CNT_ZERO;
      base_reg <= {AW{1'b0}};
    end else if (!sleep) begin
      if (load) begin
        base_reg <= addr_s2_reg;
        load_low_reg <= addr_s2_reg[1:0];
        count_reg <= `CNT_ZERO;
      end else if (cont && !step_n && active) begin
        count_reg <= count_reg + `CNT_ONE;
      end
    end
  end

  // Cycle state machine.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE, ST_READ, ST_WRITE: begin
        if (proc_start) begin
          state_next = ST_READ;
        end else if (cache_start) begin
          state_next = write_req ? ST_WRITE : ST_READ;
        end else if (deselect) begin
          state_next = ST_IDLE;
        end else if (active) begin
          state_next = write_req ? ST_WRITE : ST_READ;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
    end else if (!sleep) begin
      state_reg <= state_next;
    end
  end

  wire [AW-1:0] cur_addr = load ? addr_s2_reg : {base_reg[AW-1:2], low_addr};
  wire do_write = !sleep && (state_next == ST_WRITE) && (load || active);
  wire do_read = !sleep && (state_next == ST_READ) && (load || active);

  // Parity lane mask.
  wire [DW-1:0] lane_mask;
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : pmask
      assign lane_mask[g*LW +: LW] = {~parity_off, {(LW-1){1'b1}}};
    end
  endgenerate

  wire [DW-1:0] mem_rdata;
  burst_mem_array #(.AW(AW), .LANES(LANES), .LW(LW)) u_mem (
    .ref_clk_i(ref_clk_i),
    .addr_i(cur_addr),
    .lane_we_i(do_write ? lane_we : {LANES{1'b0}}),
    .wdata_i(din_s2_reg & lane_mask),
    .rd_en_i(do_read),
    .rdata_o(mem_rdata)
  );

  // Output pipeline and deselect latency.
  reg rd_stage_reg;
  reg drive_reg;
  reg desel_hold_reg;
  reg [DW-1:0] dout_reg;
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rd_stage_reg <= 1'b0;
      drive_reg <= 1'b0;
      desel_hold_reg <= 1'b0;
      dout_reg <= {DW{1'b0}};
    end else begin
      rd_stage_reg <= do_read;
      desel_hold_reg <= deselect && !single_desel;
      if (rd_stage_reg) begin
        dout_reg <= mem_rdata & lane_mask;
        drive_reg <= 1'b1;
      end else if (do_write || sleep) begin
        drive_reg <= 1'b0;
      end else if (deselect && single_desel) begin
        drive_reg <= 1'b0;
      end else if (desel_hold_reg) begin
        drive_reg <= 1'b0;
      end
    end
  end
  assign data_lanes_o = dout_reg;
  // Output enable input is gated directly, unsampled.
  assign data_lanes_oe_o = (drive_reg && !output_enable_n_i && !do_write)
                           ? lane_mask : {DW{1'b0}};

  read_skid_buffer #(.W(DW)) u_buf (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .flush_i(sleep),
    .in_valid_i(rd_stage_reg),
    .in_ready_o(),
    .in_data_i(mem_rdata & lane_mask),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o)
  );
  assign sleeping_o = sleep;
  assign burst_addr_o = low_addr;
  wire unused_oe = oe_n;
endmodule // sync_burst_sram_control

// ===== burst_sram_defines.vh
// Constants of the synchronous burst memory control block.
`ifndef BURST_SRAM_DEFINES_VH
`define BURST_SRAM_DEFINES_VH
`define LANES 8
`define LANE_BITS 8
`define ADDR_BITS 18
`define BURST_LEN_LOG2 2
`define CNT_ZERO 2'h0
`define CNT_ONE 2'h1
`define BUF_DEPTH 2
`define MEM_WORDS 262144
`endif

// ===== burst_mem_array.v
// Storage array with per-lane write and registered read data.
`timescale 1ns/1ps
`include "burst_sram_defines.vh"
module burst_mem_array #(
  parameter AW = `ADDR_BITS,
  parameter LANES = `LANES,
  parameter LW = `LANE_BITS + 1
) (
  input wire ref_clk_i,
  input wire [AW-1:0] addr_i,
  input wire [LANES-1:0] lane_we_i,
  input wire [LANES*LW-1:0] wdata_i,
  input wire rd_en_i,
  output reg [LANES*LW-1:0] rdata_o
);
  reg [LANES*LW-1:0] mem [0:(1<<AW)-1];
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane
      always @(posedge ref_clk_i) begin
        if (lane_we_i[g]) begin
          mem[addr_i][g*LW +: LW] <= wdata_i[g*LW +: LW];
        end
      end
    end
  endgenerate
  always @(posedge ref_clk_i) begin
    if (rd_en_i) begin
      rdata_o <= mem[addr_i];
    end
  end
endmodule // burst_mem_array

// ===== read_skid_buffer.v
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`include "burst_sram_defines.vh"
module read_skid_buffer #(
  parameter W = 72
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] slot_reg [0:1];
  reg rd_ptr_reg;
  reg wr_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;
  assign in_ready_o = (count_reg != 2'h2);
  assign out_valid_o = (count_reg != 2'h0);
  assign out_data_o = slot_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always @(posedge ref_clk_i) begin
    if (!rstn_i || flush_i) begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end
  always @(posedge ref_clk_i) begin
    if (push) begin
      slot_reg[wr_ptr_reg] <= in_data_i;
    end
  end
endmodule // read_skid_buffer

// ===== host_sink.sv
// Host side read receiver that can stall the read stream.
`timescale 1ns/1ps
module host_sink (
  input wire clk_i,
  input wire stall_i,
  input wire valid_i,
  input wire [71:0] data_i,
  output wire ready_o,
  output reg [71:0] word_o,
  output reg [7:0] count_o = 8'h00
);
  assign ready_o = !stall_i;
  always @(posedge clk_i) begin
    if (valid_i && ready_o) begin
      word_o <= data_i;
      count_o <= count_o + 8'h01;
    end
  end
endmodule // host_sink

// ===== sram_ctrl_props.sv
// Concurrent checks on the burst memory control ports.
`timescale 1ns/1ps
module sram_ctrl_props #(
  parameter LANES = 8,
  parameter LW = 9
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire select_low_first_n_i,
  input wire select_high_second_i,
  input wire select_low_third_n_i,
  input wire processor_strobe_n_i,
  input wire cache_strobe_n_i,
  input wire global_write_n_i,
  input wire output_enable_n_i,
  input wire sleep_request_i,
  input wire deselect_latency_sel_i,
  input wire [LANES*LW-1:0] data_lanes_oe_o,
  input wire rd_valid_o,
  input wire sleeping_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire sel = !select_low_first_n_i && select_high_second_i && !select_low_third_n_i;
  wire idle = processor_strobe_n_i && !cache_strobe_n_i && select_low_first_n_i;
  sequence s_rd; !sleep_request_i[*3] ##1 sel && !processor_strobe_n_i; endsequence
  sequence s_desel; idle[*3]; endsequence
  property p_oe; output_enable_n_i |-> data_lanes_oe_o == 0; endproperty
  a_oe: assert property (p_oe) else $error("drive while disabled");
  property p_rd; s_rd ##1 !sleep_request_i[*4] |-> ##[0:4] rd_valid_o; endproperty
  a_rd: assert property (p_rd) else $error("read lost");
  property p_wr; sel && !global_write_n_i && !cache_strobe_n_i && processor_strobe_n_i
    ##1 idle[*5] |-> data_lanes_oe_o == 0; endproperty
  a_wr: assert property (p_wr) else $error("drive during write");
  property p_slp; sleep_request_i[*4] |-> sleeping_o; endproperty
  a_slp: assert property (p_slp) else $error("no standby");
  property p_wake; !sleep_request_i[*4] |-> !sleeping_o; endproperty
  a_wake: assert property (p_wake) else $error("stuck in standby");
  property p_quiet; sleeping_o[*2] |-> data_lanes_oe_o == 0 && !rd_valid_o; endproperty
  a_quiet: assert property (p_quiet) else $error("active in standby");
  property p_scd; s_desel ##0 deselect_latency_sel_i |-> ##3 data_lanes_oe_o == 0; endproperty
  a_scd: assert property (p_scd) else $error("single deselect late");
  property p_dcd; s_desel ##0 !deselect_latency_sel_i |-> ##4 data_lanes_oe_o == 0; endproperty
  a_dcd: assert property (p_dcd) else $error("dual deselect late");
endmodule // sram_ctrl_props
bind sync_burst_sram_control sram_ctrl_props #(.LANES(LANES), .LW(LW)) i_sram_ctrl_props (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .select_low_first_n_i(select_low_first_n_i),
  .select_high_second_i(select_high_second_i), .select_low_third_n_i(select_low_third_n_i),
  .processor_strobe_n_i(processor_strobe_n_i), .cache_strobe_n_i(cache_strobe_n_i),
  .global_write_n_i(global_write_n_i), .output_enable_n_i(output_enable_n_i),
  .sleep_request_i(sleep_request_i), .deselect_latency_sel_i(deselect_latency_sel_i),
  .data_lanes_oe_o(data_lanes_oe_o), .rd_valid_o(rd_valid_o), .sleeping_o(sleeping_o));

// ===== tb.sv
// Self-checking bench for the burst memory control block.
`timescale 1ns/1ps
module tb;
  reg clk = 0, rstn = 0, e1 = 1, e2 = 1, e3 = 0, ps = 1, cs = 0, burst_step_n = 1, gw = 1, bw = 1;
  reg oen = 0, slp = 0, ord = 0, dsel = 1, stall = 0, pstrap = 0;
  reg [7:0] lw = 8'hff, last = 8'h00;
  reg [17:0] addr = 18'h0_0010;
  reg [71:0] din = 72'h0, w;
  reg [1:0] s, e;
  wire [71:0] dout, doe, rd, word;
  wire rv, rr, slpo;
  wire [1:0] ba;
  wire [7:0] cnt;
  integer mismatches = 0, total_checks = 0, i, n, k;
  wire [71:0] exp_word = {{5{9'h1a5}}, 9'h0c3, 9'h1a5, 9'h0c3};
  initial forever #25 clk = ~clk;
  sync_burst_sram_control i_sync_burst_sram_control (.ref_clk_i(clk), .rstn_i(rstn),
    .addr_i(addr), .select_low_first_n_i(e1), .select_high_second_i(e2),
    .select_low_third_n_i(e3), .processor_strobe_n_i(ps), .cache_strobe_n_i(cs),
    .burst_step_n_i(burst_step_n), .global_write_n_i(gw), .byte_write_gate_n_i(bw),
    .lane_write_n_i(lw), .output_enable_n_i(oen), .sleep_request_i(slp),
    .burst_order_sel_i(ord), .deselect_latency_sel_i(dsel), .parity_lane_strap_n_i(pstrap),
    .data_lanes_i(din), .data_lanes_o(dout), .data_lanes_oe_o(doe), .rd_valid_o(rv),
    .rd_ready_i(rr), .rd_data_o(rd), .sleeping_o(slpo), .burst_addr_o(ba));
  host_sink i_host_sink (.clk_i(clk), .stall_i(stall), .valid_i(rv), .data_i(rd),
    .ready_o(rr), .word_o(word), .count_o(cnt));
  task check(input [71:0] seen, exp, input string what);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task cmd(input [3:0] c, input [7:0] l, input [71:0] d);
    begin
      @(negedge clk);
      {e1, ps, cs, gw, bw} = {1'b0, c};
      lw = l;
      din = d;
      @(negedge clk);
      {e1, ps, cs, gw, bw} = 5'h1b;
    end
  endtask
  task get;
    begin
      k = 0;
      while (cnt === last && k < 20) begin
        @(negedge clk);
        k = k + 1;
      end
      last = last + 8'h01;
      w = word;
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    print_verdict;
  end
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1;
    cmd(4'h9, 8'hff, {8{9'h1a5}});
    repeat (6) @(negedge clk);
    cmd(4'ha, 8'hfa, {8{9'h0c3}});
    cmd(4'hb, 8'h00, {8{9'h1ff}});
    cmd(4'h4, 8'h00, 72'h0);
    get;
    check(w, exp_word, "cache read");
    get;
    check(w, exp_word, "processor read");
    check(dout, exp_word, "output lanes");
    $display("write test done");
    stall = 1;
    dsel = 0;
    cmd(4'h7, 8'hff, 72'h0);
    cmd(4'h7, 8'hff, 72'h0);
    repeat (8) @(negedge clk);
    check(cnt, last, "stalled count");
    stall = 0;
    get;
    check(w, exp_word, "first held word");
    get;
    check(w, exp_word, "second held word");
    dsel = 1;
    $display("stall test done");
    for (i = 0; i < 2; i = i + 1) begin
      {e2, e3} = {i[0], i[0]};
      cmd(4'h7, 8'hff, 72'h0);
      repeat (8) @(negedge clk);
      check(cnt, last, "unselected read");
    end
    {e2, e3} = 2'b10;
    $display("select test done");
    for (i = 0; i < 4; i = i + 1) begin
      ord = i[1];
      s = i[0] + 2'h1;
      addr = {16'h0000, s};
      {e1, ps, cs} = 3'b001;
      @(negedge clk);
      {e1, ps, cs, burst_step_n} = 4'b1110;
      k = 0;
      while (ba !== s && k < 10) begin
        @(negedge clk);
        k = k + 1;
      end
      for (n = 1; n < 5; n = n + 1) begin
        @(negedge clk);
        e = ord ? s ^ n[1:0] : s + n[1:0];
        check(ba, e, "burst address");
      end
      burst_step_n = 1;
      repeat (3) @(negedge clk);
      e = ba;
      repeat (2) @(negedge clk);
      check(ba, e, "suspended address");
      {e1, cs} = 2'b10;
      repeat (8) @(negedge clk);
      last = cnt;
    end
    $display("burst test done");
    slp = 1;
    repeat (6) @(negedge clk);
    check(slpo, 1, "standby");
    cmd(4'h7, 8'hff, 72'h0);
    repeat (8) @(negedge clk);
    check(cnt, last, "read in standby");
    slp = 0;
    repeat (6) @(negedge clk);
    check(slpo, 0, "awake");
    addr = 18'h0_0010;
    pstrap = 1;
    cmd(4'h7, 8'hff, 72'h0);
    repeat (3) @(negedge clk);
    check(doe, {8{9'h0ff}}, "lane drive");
    check(dout, exp_word & {8{9'h0ff}}, "parity lanes off");
    oen = 1;
    #1 check(doe, 0, "drive off");
    get;
    check(w, exp_word & {8{9'h0ff}}, "parity stream");
    $display("standby test done");
    print_verdict;
  end
endmodule // tb
